/* src/dinac_top.sv */
// Supervisor: standby, third input, contact alarms and display choice
// Behaviour
// - Powered up: active or standby, dark
// - Leaving standby replays power-up
// - Active/standby state kept across outages
// - Standby key works only when enabled
// - Third input: probe, contact or off
// - Four unit/resolution modes selectable
// - Each input gets its own offset
// - Normal display selector picks shown item
// - Display key steps through variables
// - Browsing ends 15 s after last press
// - Contact activation acts after input delay
// - Code zero ignores the contact
// - Code one drives first alarm
// - Code two drives second alarm
// - Code three drives both alarms
// - Codes four-six also disable control outputs
// - Negative codes invert contact sense
// - Contact raw state shown open/closed
// - Alarm outputs follow direct or inverted polarity
`timescale 1ns/100ps
`include "dinac_map.svh"
module dinac_top #(
  parameter int BROWSE_CYC = `DINAC_BROWSE_CYC  // Browse timeout in cycles
) (
  input  wire logic                      clk_i,          // 100 MHz clock
  input  wire logic                      rst_i,          // Sync reset, high
  input  wire logic                      nv_valid_i,     // Stored state is valid
  input  wire logic                      nv_active_i,    // Stored active state
  output logic                           nv_wr_o,        // Store request pulse
  output logic                           nv_active_o,    // Value to store
  input  wire logic                      standby_key_enable_i, // Key enable
  input  wire logic                      stby_key_i,     // Key press pulse
  input  wire logic                      disp_key_i,     // Display key pulse
  input  wire logic                      clock_en_i,     // Clock enabled
  input  wire dinac_pkg::dinac_p3_t      third_input_usage_i,  // Input use
  input  wire dinac_pkg::dinac_unit_t    unit_sel_i,     // Unit/resolution
  input  wire dinac_pkg::dinac_show_t    normal_display_select_i, // Normal view
  input  wire logic signed [`DINAC_FC_W-1:0] input_function_code_i, // Function
  input  wire logic [`DINAC_DLY_W-1:0]   input_delay_time_i, // Delay in ms
  input  wire logic                      contact_closed_i, // Contact closed
  input  wire logic signed [`DINAC_TEMP_W-1:0] probe_one_i,   // Raw probe 1
  input  wire logic signed [`DINAC_TEMP_W-1:0] probe_two_i,   // Raw probe 2
  input  wire logic signed [`DINAC_TEMP_W-1:0] probe_three_i, // Raw probe 3
  input  wire logic signed [`DINAC_TEMP_W-1:0] probe_one_offset_i,   // Offset 1
  input  wire logic signed [`DINAC_TEMP_W-1:0] probe_two_offset_i,   // Offset 2
  input  wire logic signed [`DINAC_TEMP_W-1:0] probe_three_offset_i, // Offset 3
  input  wire logic signed [`DINAC_TEMP_W-1:0] differential_setpoint_i, // SP d
  input  wire logic signed [`DINAC_TEMP_W-1:0] auxiliary_setpoint_i,    // SP a
  input  wire logic [1:0]                alarm_assigned_i, // Alarm has output
  input  wire logic [1:0]                alarm_inverted_i, // Inverted polarity
  output logic                           active_o,       // Control running
  output logic                           powerup_o,      // Power-up pulse
  output logic                           ctrl_disable_o, // Force outputs off
  output logic [1:0]                     alarm_req_o,    // Alarm requests
  output logic [1:0]                     alarm_relay_o,  // Relay closed
  output logic                           alarm_label_o,  // Alarm label shown
  output dinac_pkg::dinac_disp_t         disp_kind_o,    // Display content
  output logic [`DINAC_VIEW_W-1:0]       disp_var_o,     // Browsed variable
  output logic signed [`DINAC_TEMP_W-1:0] disp_value_o,  // Displayed value
  output dinac_pkg::dinac_unit_t         disp_unit_o     // Unit/resolution
);
  import dinac_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Offset-corrected reading, used for all three inputs
  function automatic logic signed [`DINAC_TEMP_W-1:0] calib(
    input logic signed [`DINAC_TEMP_W-1:0] raw,
    input logic signed [`DINAC_TEMP_W-1:0] ofs);
    calib = raw + ofs;
  endfunction

  // ----------------------------------------------------------------------
  // Time base: one pulse per millisecond, one for display blink
  // ----------------------------------------------------------------------
  logic [16:0] ms_ff, nxt_ms;        // Cycle divider
  logic [9:0]  blk_ff, nxt_blk;      // Blink ms counter
  logic        ph_ff, nxt_ph;        // Label/value phase
  logic        ms_tick;              // Millisecond enable

  assign ms_tick = (ms_ff == 17'(`DINAC_MS_CYC - 1));

  // Divider next values
  always_comb begin
    nxt_ms  = ms_tick ? '0 : ms_ff + 1'b1;
    nxt_blk = blk_ff;
    nxt_ph  = ph_ff;
    if (ms_tick) begin
      if (blk_ff == 10'(`DINAC_BLINK_MS - 1)) begin
        nxt_blk = '0;
        nxt_ph  = ~ph_ff;
      end else begin
        nxt_blk = blk_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_ff  <= '0;
      blk_ff <= '0;
      ph_ff  <= 1'b0;
    end else begin
      ms_ff  <= nxt_ms;
      blk_ff <= nxt_blk;
      ph_ff  <= nxt_ph;
    end
  end

  // ----------------------------------------------------------------------
  // Active / standby
  // ----------------------------------------------------------------------
  logic act_ff, nxt_act;     // Active state
  logic boot_ff, nxt_boot;   // Restore pending after reset
  logic pu_ff, nxt_pu;       // Power-up pulse
  logic wr_ff, nxt_wr;       // Store pulse

  // Restore once after reset, then follow the key
  always_comb begin
    nxt_act  = act_ff;
    nxt_boot = 1'b0;
    nxt_pu   = 1'b0;
    nxt_wr   = 1'b0;
    if (boot_ff) begin
      nxt_act = nv_valid_i ? nv_active_i : 1'b1;
      nxt_pu  = nv_valid_i ? nv_active_i : 1'b1;
    end else if (stby_key_i && standby_key_enable_i) begin
      nxt_act = ~act_ff;
      nxt_wr  = 1'b1;
      nxt_pu  = ~act_ff;
    end
  end

  // Reset holds standby until the stored state is read back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_ff  <= 1'b0;
      boot_ff <= 1'b1;
      pu_ff   <= 1'b0;
      wr_ff   <= 1'b0;
    end else begin
      act_ff  <= nxt_act;
      boot_ff <= nxt_boot;
      pu_ff   <= nxt_pu;
      wr_ff   <= nxt_wr;
    end
  end

  assign active_o    = act_ff;
  assign powerup_o   = pu_ff;
  assign nv_wr_o     = wr_ff;
  assign nv_active_o = act_ff;

  // ----------------------------------------------------------------------
  // Contact decode
  // ----------------------------------------------------------------------
  logic                   use_cont;   // Third input is a contact
  logic [`DINAC_FC_W-1:0] mag;        // Code magnitude
  logic                   fc_ok;      // Code non-zero, magnitude up to 6; -8 also passes
  logic                   cont_act;   // Contact at active level
  logic                   qual;       // Delayed activity

  assign use_cont = (third_input_usage_i == DINAC_P3_CONT);
  assign mag = input_function_code_i[`DINAC_FC_W-1] ?
               `DINAC_FC_W'(-input_function_code_i) : input_function_code_i;
  assign fc_ok = (input_function_code_i != `DINAC_FC_OFF) &&
                 ($signed(mag) <= `DINAC_FC_MAX);
  // Negative codes make the open contact the active one
  assign cont_act = use_cont && fc_ok && act_ff &&
                    (contact_closed_i ^ input_function_code_i[`DINAC_FC_W-1]);

  dinac_qual u_qual (
    .clk_i     (clk_i),
    .rst_i     (rst_i | pu_ff),
    .ms_tick_i (ms_tick),
    .active_i  (cont_act),
    .delay_i   (input_delay_time_i),
    .qual_o    (qual)
  );

  // ----------------------------------------------------------------------
  // Alarm and disable outputs, registered
  // ----------------------------------------------------------------------
  logic [1:0] req_ff, nxt_req;   // Alarm requests
  logic       dis_ff, nxt_dis;   // Control disable
  logic [1:0] rel_ff, nxt_rel;   // Relay states

  // Map code magnitude to alarms and control blocking
  always_comb begin
    nxt_req = 2'b00;
    nxt_dis = 1'b0;
    if (qual) begin
      case (mag)
        4'h1: nxt_req = 2'b01;
        4'h2: nxt_req = 2'b10;
        4'h3: nxt_req = 2'b11;
        4'h4: begin nxt_req = 2'b01; nxt_dis = 1'b1; end
        4'h5: begin nxt_req = 2'b10; nxt_dis = 1'b1; end
        4'h6: begin nxt_req = 2'b11; nxt_dis = 1'b1; end
        default: nxt_req = 2'b00;
      endcase
    end
    // Unassigned alarms leave the relay open
    nxt_rel = alarm_assigned_i & (nxt_req ^ alarm_inverted_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ff <= 2'b00;
      dis_ff <= 1'b0;
      rel_ff <= 2'b00;
    end else begin
      req_ff <= nxt_req;
      dis_ff <= nxt_dis;
      rel_ff <= nxt_rel;
    end
  end

  assign alarm_req_o    = req_ff;
  assign ctrl_disable_o = dis_ff;
  assign alarm_relay_o  = rel_ff;
  assign alarm_label_o  = |req_ff;

  // ----------------------------------------------------------------------
  // Browsing of variables
  // ----------------------------------------------------------------------
  logic                     brw_ff, nxt_brw;  // Browsing active
  logic [`DINAC_VIEW_W-1:0] var_ff, nxt_var;  // Current variable
  logic [31:0]              to_ff, nxt_to;    // Timeout counter
  logic [`DINAC_VIEW_W-1:0] last_var;         // Last index

  assign last_var = clock_en_i ? `DINAC_VIEW_LAST_CK : `DINAC_VIEW_LAST_NC;

  // Key steps; silence for the timeout returns to normal
  always_comb begin
    nxt_brw = brw_ff;
    nxt_var = var_ff;
    nxt_to  = to_ff;
    if (!act_ff) begin
      nxt_brw = 1'b0;
      nxt_var = '0;
      nxt_to  = '0;
    end else if (disp_key_i) begin
      nxt_to  = '0;
      nxt_brw = 1'b1;
      if (!brw_ff || var_ff >= last_var) begin
        nxt_var = brw_ff ? '0 : var_ff;
      end else begin
        nxt_var = var_ff + 1'b1;
      end
    end else if (brw_ff) begin
      if (to_ff >= 32'(BROWSE_CYC - 1)) begin
        nxt_brw = 1'b0;
        nxt_var = '0;
        nxt_to  = '0;
      end else begin
        nxt_to = to_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brw_ff <= 1'b0;
      var_ff <= '0;
      to_ff  <= '0;
    end else begin
      brw_ff <= nxt_brw;
      var_ff <= nxt_var;
      to_ff  <= nxt_to;
    end
  end

  // ----------------------------------------------------------------------
  // Display selection, registered
  // ----------------------------------------------------------------------
  dinac_disp_t                   kind_ff, nxt_kind;  // Display kind
  logic signed [`DINAC_TEMP_W-1:0] val_ff, nxt_val;  // Display value
  logic signed [`DINAC_TEMP_W-1:0] p1, p2, p3;       // Calibrated readings
  dinac_show_t                   sel;                // Item to show
  logic                          cont_kind;          // Show contact state

  assign p1 = calib(probe_one_i, probe_one_offset_i);
  assign p2 = calib(probe_two_i, probe_two_offset_i);
  assign p3 = calib(probe_three_i, probe_three_offset_i);

  // Browse order 0..3 maps onto P1, P2, difference, P3
  always_comb begin
    sel = normal_display_select_i;
    if (brw_ff) begin
      case (var_ff)
        3'h0: sel = DINAC_SHOW_P1;
        3'h1: sel = DINAC_SHOW_P2;
        3'h2: sel = DINAC_SHOW_DIFF;
        3'h3: sel = DINAC_SHOW_P3;
        default: sel = DINAC_SHOW_OFF; // Time-of-day fed outside
      endcase
    end
    cont_kind = use_cont && (sel == DINAC_SHOW_P3);
    case (sel)
      DINAC_SHOW_P1:   nxt_val = p1;
      DINAC_SHOW_P2:   nxt_val = p2;
      DINAC_SHOW_P3:   nxt_val = p3;
      DINAC_SHOW_DIFF: nxt_val = p1 - p2;
      DINAC_SHOW_SPD:  nxt_val = differential_setpoint_i;
      DINAC_SHOW_SPA:  nxt_val = auxiliary_setpoint_i;
      default:         nxt_val = '0;
    endcase
    if (!act_ff) begin
      nxt_kind = DINAC_D_STBY;
    end else if (brw_ff && !ph_ff) begin
      nxt_kind = DINAC_D_LABEL;
    end else if (!brw_ff && |req_ff && !ph_ff) begin
      nxt_kind = DINAC_D_ALARM;
    end else if (cont_kind) begin
      nxt_kind = contact_closed_i ? DINAC_D_CONT_CL : DINAC_D_CONT_OP;
    end else if (sel == DINAC_SHOW_OFF || (sel == DINAC_SHOW_P3 &&
                 third_input_usage_i == DINAC_P3_OFF)) begin
      nxt_kind = DINAC_D_BLANK;
    end else begin
      nxt_kind = DINAC_D_VALUE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind_ff <= DINAC_D_STBY;
      val_ff  <= '0;
    end else begin
      kind_ff <= nxt_kind;
      val_ff  <= nxt_val;
    end
  end

  assign disp_kind_o  = kind_ff;
  assign disp_value_o = val_ff;
  assign disp_var_o   = var_ff;
  assign disp_unit_o  = unit_sel_i;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_stby_dark;
    @(posedge clk_i) disable iff (rst_i) !act_ff |=> kind_ff == DINAC_D_STBY;
  endproperty
  a_stby_dark: assert property (p_stby_dark) else $error("standby not dark");
  property p_key_off;
    @(posedge clk_i) disable iff (rst_i)
      (!boot_ff && !standby_key_enable_i) |=> act_ff == $past(act_ff);
  endproperty
  a_key_off: assert property (p_key_off) else $error("key toggled state");
  property p_wake_pu;
    @(posedge clk_i) disable iff (rst_i) $rose(act_ff) |-> pu_ff;
  endproperty
  a_wake_pu: assert property (p_wake_pu) else $error("no power-up pulse");
  property p_store;
    @(posedge clk_i) disable iff (rst_i) wr_ff |-> act_ff != $past(act_ff);
  endproperty
  a_store: assert property (p_store) else $error("store without change");
  property p_code0;
    @(posedge clk_i) disable iff (rst_i)
      input_function_code_i == `DINAC_FC_OFF |=> req_ff == 2'b00;
  endproperty
  a_code0: assert property (p_code0) else $error("code zero raised alarm");
  property p_dis;
    @(posedge clk_i) disable iff (rst_i) dis_ff |-> req_ff != 2'b00;
  endproperty
  a_dis: assert property (p_dis) else $error("disable without alarm");
  property p_rel;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> rel_ff == (alarm_assigned_i & (req_ff ^ alarm_inverted_i)) ||
               $changed(alarm_assigned_i) || $changed(alarm_inverted_i);
  endproperty
  a_rel: assert property (p_rel) else $error("relay polarity wrong");
  property p_drop;
    @(posedge clk_i) disable iff (rst_i) !cont_act |=> ##1 req_ff == 2'b00;
  endproperty
  a_drop: assert property (p_drop) else $error("alarm held after release");
  c_alarm: cover property (@(posedge clk_i) disable iff (rst_i) $rose(|req_ff));
  c_wake:  cover property (@(posedge clk_i) disable iff (rst_i) $rose(act_ff));
  c_brw:   cover property (@(posedge clk_i) disable iff (rst_i) $fell(brw_ff));

endmodule // dinac_top

/* src/dinac_map.svh */
// Constants and encodings for the digital input and alarm supervisor
`ifndef DINAC_MAP_SVH
`define DINAC_MAP_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DINAC_CLK_HZ        100000000
`define DINAC_BROWSE_SEC    15
`define DINAC_BROWSE_CYC    (`DINAC_BROWSE_SEC * `DINAC_CLK_HZ)
`define DINAC_MS_CYC        (`DINAC_CLK_HZ / 1000)
`define DINAC_BLINK_MS      500

// ----------------------------------------------------------------------
// Field widths and codes
// ----------------------------------------------------------------------
`define DINAC_FC_W          4
`define DINAC_FC_OFF        4'sh0
`define DINAC_FC_MAX        4'sh6
`define DINAC_DLY_W         16
`define DINAC_TEMP_W        16
`define DINAC_VIEW_W        3
`define DINAC_VIEW_LAST_NC  3'h3
`define DINAC_VIEW_LAST_CK  3'h6

`endif

/* src/dinac_pkg.sv */
// Types for the digital input and alarm supervisor
package dinac_pkg;

  // Third input usage
  typedef enum logic [1:0] {
    DINAC_P3_OFF  = 2'b00,
    DINAC_P3_AUX  = 2'b01,
    DINAC_P3_CONT = 2'b10
  } dinac_p3_t;

  // Unit and resolution
  typedef enum logic [1:0] {
    DINAC_C_WHOLE = 2'b00,
    DINAC_C_TENTH = 2'b01,
    DINAC_F_WHOLE = 2'b10,
    DINAC_F_TENTH = 2'b11
  } dinac_unit_t;

  // Normal display selection
  typedef enum logic [2:0] {
    DINAC_SHOW_P1   = 3'b000,
    DINAC_SHOW_P2   = 3'b001,
    DINAC_SHOW_P3   = 3'b010,
    DINAC_SHOW_DIFF = 3'b011,
    DINAC_SHOW_SPD  = 3'b100,
    DINAC_SHOW_SPA  = 3'b101,
    DINAC_SHOW_OFF  = 3'b110
  } dinac_show_t;

  // What the display is showing
  typedef enum logic [3:0] {
    DINAC_D_BLANK   = 4'h0,
    DINAC_D_VALUE   = 4'h1,
    DINAC_D_LABEL   = 4'h2,
    DINAC_D_ALARM   = 4'h3,
    DINAC_D_CONT_OP = 4'h4,
    DINAC_D_CONT_CL = 4'h5,
    DINAC_D_STBY    = 4'h6
  } dinac_disp_t;

  // Contact qualifier states
  typedef enum logic [1:0] {
    DINAC_Q_IDLE = 2'b00,
    DINAC_Q_WAIT = 2'b01,
    DINAC_Q_ACT  = 2'b10
  } dinac_qst_t;

endpackage : dinac_pkg

/* src/dinac_qual.sv */
// Contact delay qualifier: active only after the programmed delay
`timescale 1ns/100ps
`include "dinac_map.svh"
module dinac_qual (
  input  wire logic                    clk_i,     // System clock
  input  wire logic                    rst_i,     // Sync reset, high
  input  wire logic                    ms_tick_i, // One pulse per ms
  input  wire logic                    active_i,  // Contact at active level
  input  wire logic [`DINAC_DLY_W-1:0] delay_i,   // Delay in ms
  output logic                         qual_o     // Qualified activity
);
  import dinac_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dinac_qst_t              st_ff, nxt_st;       // Qualifier state
  logic [`DINAC_DLY_W-1:0] cnt_ff, nxt_cnt;     // Elapsed ms

  // Next state: a drop before expiry restarts the count
  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      DINAC_Q_IDLE: begin
        nxt_cnt = '0;
        if (active_i && delay_i == '0) begin
          nxt_st = DINAC_Q_ACT;
        end else if (active_i) begin
          nxt_st = DINAC_Q_WAIT;
        end
      end
      DINAC_Q_WAIT: begin
        if (!active_i) begin
          nxt_st  = DINAC_Q_IDLE;
          nxt_cnt = '0;
        end else if (ms_tick_i) begin
          nxt_cnt = cnt_ff + 1'b1;
          if (nxt_cnt >= delay_i) begin
            nxt_st = DINAC_Q_ACT;
          end
        end
      end
      DINAC_Q_ACT: begin
        if (!active_i) begin
          nxt_st = DINAC_Q_IDLE;
        end
      end
      default: nxt_st = DINAC_Q_IDLE;
    endcase
  end

  // Register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff  <= DINAC_Q_IDLE;
      cnt_ff <= '0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  assign qual_o = (st_ff == DINAC_Q_ACT);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // A drop while waiting must leave no partial count behind
  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff == DINAC_Q_WAIT && !active_i) |=> st_ff == DINAC_Q_IDLE && cnt_ff == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("pending activation kept");

endmodule // dinac_qual

/* sim/dinac_partner.sv */
// Far-side model: dry contact and three temperature probes
`timescale 1ns/100ps
module dinac_partner (
  input  wire logic               clk_i,       // System clock
  input  wire logic               close_i,     // Bench asks contact closed
  input  wire logic signed [15:0] temp_one_i,  // Bench probe one temperature
  input  wire logic signed [15:0] temp_two_i,  // Bench probe two temperature
  input  wire logic signed [15:0] temp_thr_i,  // Bench probe three temperature
  output logic                    closed_o,    // Contact level at the pin
  output logic signed [15:0]      probe_one_o, // Probe one reading
  output logic signed [15:0]      probe_two_o, // Probe two reading
  output logic signed [15:0]      probe_thr_o  // Probe three reading
);
  // ------------------------------------------------------------
  // Contact and probe state
  // ------------------------------------------------------------
  // Register the far side so changes land only on the sampling edge;
  // readings lag one cycle like a real converter
  always_ff @(posedge clk_i) begin
    closed_o    <= close_i;
    probe_one_o <= temp_one_i;
    probe_two_o <= temp_two_i;
    probe_thr_o <= temp_thr_i;
  end
endmodule // dinac_partner

/* sim/digital_input_alarm_control_bench.sv */
// Self-checking bench for the digital input and alarm supervisor
`timescale 1ns/100ps
module digital_input_alarm_control_bench;
  import dinac_pkg::*;
  // ------------------------------------------------------------
  // Drives, outputs and counters
  // ------------------------------------------------------------
  localparam int LIMIT = 5000;  // Run needs about 800 cycles
  logic clk_i = 1'b0, rst_i = 1'b1, nv_valid = 1'b0, nv_act = 1'b0;
  logic key_en = 1'b0, stby_key = 1'b0, disp_key = 1'b0, clk_en = 1'b0, close = 1'b0;
  logic [1:0] asg = 2'h0, inv = 2'h0;             // Alarm assignment, polarity
  logic signed [3:0] code = 4'sh0;                // Input function code
  logic [15:0] dly = 16'h0;                       // Input delay in ms
  logic signed [15:0] temp[3] = '{default: 16'sh0}, ofs[3] = '{default: 16'sh0};
  logic signed [15:0] differential_setpoint = 16'sh0, auxiliary_setpoint = 16'sh0; // Setpoints
  dinac_p3_t usage = DINAC_P3_CONT;
  dinac_unit_t unit = DINAC_C_WHOLE, unit_o;
  dinac_show_t sel = DINAC_SHOW_P1;
  dinac_disp_t kind;
  logic closed, nv_wr, nv_out, active, pwr, dis, lbl;
  logic [1:0] req, relay;
  logic [2:0] vidx, e;
  logic signed [15:0] probe[3], val;
  int mismatches = 0, cmp_count = 0, cycles = 0, wr_cnt = 0, pu_cnt = 0, ev;
  int unsigned rnd;
  // ------------------------------------------------------------
  // Far side and design
  // ------------------------------------------------------------
  dinac_partner i_dinac_partner (.clk_i(clk_i), .close_i(close), .temp_one_i(temp[0]),
    .temp_two_i(temp[1]), .temp_thr_i(temp[2]), .closed_o(closed),
    .probe_one_o(probe[0]), .probe_two_o(probe[1]), .probe_thr_o(probe[2]));
  dinac_top #(.BROWSE_CYC(200)) i_dinac_top (.clk_i(clk_i), .rst_i(rst_i),
    .nv_valid_i(nv_valid), .nv_active_i(nv_act), .nv_wr_o(nv_wr), .nv_active_o(nv_out),
    .standby_key_enable_i(key_en), .stby_key_i(stby_key), .disp_key_i(disp_key),
    .clock_en_i(clk_en), .third_input_usage_i(usage), .unit_sel_i(unit),
    .normal_display_select_i(sel), .input_function_code_i(code), .input_delay_time_i(dly),
    .contact_closed_i(closed), .probe_one_i(probe[0]), .probe_two_i(probe[1]),
    .probe_three_i(probe[2]), .probe_one_offset_i(ofs[0]), .probe_two_offset_i(ofs[1]),
    .probe_three_offset_i(ofs[2]), .differential_setpoint_i(differential_setpoint),
    .auxiliary_setpoint_i(auxiliary_setpoint), .alarm_assigned_i(asg), .alarm_inverted_i(inv),
    .active_o(active), .powerup_o(pwr), .ctrl_disable_o(dis), .alarm_req_o(req),
    .alarm_relay_o(relay), .alarm_label_o(lbl), .disp_kind_o(kind), .disp_var_o(vidx),
    .disp_value_o(val), .disp_unit_o(unit_o));
  initial forever #5 clk_i = ~clk_i;
  // Pulse counters and hang guard; pulses are one cycle, so count them
  always @(posedge clk_i) begin
    cycles++;
    if (nv_wr === 1'b1) wr_cnt++;
    if (pwr === 1'b1) pu_cnt++;
    if (cycles == LIMIT) begin
      mismatches++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // Helpers and reference model
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One-cycle key pulse, then let the answer land
  task automatic press(input bit is_disp);
    @(posedge clk_i) if (is_disp) disp_key <= 1'b1; else stby_key <= 1'b1;
    @(posedge clk_i) begin
      disp_key <= 1'b0;
      stby_key <= 1'b0;
    end
    tick(2);
  endtask
  task automatic do_reset(input logic v, input logic a);
    @(posedge clk_i) begin
      rst_i <= 1'b1;
      nv_valid <= v;
      nv_act <= a;
    end
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(3);
  endtask
  // {disable, second, first}; active level is closed unless code negative
  function automatic logic [2:0] exp_alarm(input int c, input logic cl, input logic on);
    int m;
    m = (c < 0) ? -c : c;
    if (!on || m == 0 || m > 6 || ((c < 0) == cl)) return 3'h0;
    return {m > 3, (m % 3) != 1, (m % 3) != 2};
  endfunction
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rnd = $urandom(32'h14a8845c);
    do_reset(1'b1, 1'b0);
    chk(active, 1'b0);
    chk(kind, DINAC_D_STBY);
    press(1'b0);
    chk(active, 1'b0);
    chk(wr_cnt, 0);
    @(posedge clk_i) key_en <= 1'b1;
    press(1'b0);
    chk({active, nv_out}, 2'h3);
    chk({wr_cnt[7:0], pu_cnt[7:0]}, 16'h0101);
    do_reset(1'b0, 1'b0);
    chk(active, 1'b1);
    chk(pu_cnt, 2);
    // Every function code, both contact levels, random relay wiring
    for (int c = -8; c < 8; c++) for (int k = 0; k < 2; k++) begin
      @(posedge clk_i) begin
        code <= 4'(c);
        close <= k[0];
        asg <= 2'($urandom);
        inv <= 2'($urandom);
      end
      tick(10);
      e = exp_alarm(c, k[0], 1'b1);
      chk(req, e[1:0]);
      chk(dis, e[2]);
      chk(lbl, |e[1:0]);
      chk(relay, asg & (e[1:0] ^ inv));
    end
    // Short closure against a 2 ms delay never qualifies
    @(posedge clk_i) begin
      code <= 4'sh1;
      dly <= 16'h2;
      close <= 1'b1;
    end
    tick(20);
    chk(req, 2'h0);
    @(posedge clk_i) close <= 1'b0;
    tick(30);
    chk(req, 2'h0);
    // Standby blocks the contact; waking replays power-up and re-qualifies
    @(posedge clk_i) dly <= 16'h0;
    press(1'b0);
    @(posedge clk_i) close <= 1'b1;
    tick(10);
    chk({req, kind}, {2'h0, DINAC_D_STBY});
    press(1'b0);
    tick(10);
    chk({req, pu_cnt[3:0]}, 6'h13);
    @(posedge clk_i) usage <= DINAC_P3_OFF;
    tick(10);
    chk(req, 2'h0);
    // Normal display table with random probe data
    @(posedge clk_i) begin
      usage <= DINAC_P3_AUX;
      differential_setpoint <= 16'($urandom_range(500));
      auxiliary_setpoint <= 16'($urandom_range(500));
      for (int i = 0; i < 3; i++) begin
        temp[i] <= 16'($urandom_range(2000));
        ofs[i] <= 16'($urandom_range(200) - 100);
      end
    end
    for (int s = 0; s < 7; s++) begin
      @(posedge clk_i) begin
        sel <= dinac_show_t'(s);
        unit <= dinac_unit_t'(s % 4);
      end
      tick(4);
      ev = (s == 0) ? temp[0] + ofs[0] : (s == 1) ? temp[1] + ofs[1]
         : (s == 2) ? temp[2] + ofs[2] : (s == 3) ? temp[0] + ofs[0] - temp[1] - ofs[1]
         : (s == 4) ? differential_setpoint : auxiliary_setpoint;
      chk(kind, (s == 6) ? DINAC_D_BLANK : DINAC_D_VALUE);
      if (s < 6) chk(val, ev[15:0]);
      chk(unit_o, 16'(s % 4));
    end
    // Contact shown open or closed on the third-probe view
    @(posedge clk_i) begin
      usage <= DINAC_P3_CONT;
      sel <= DINAC_SHOW_P3;
      code <= 4'sh0;
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i) close <= k[0];
      tick(6);
      chk(kind, k ? DINAC_D_CONT_CL : DINAC_D_CONT_OP);
    end
    // Browse list wraps after probe three, later after the day
    @(posedge clk_i) sel <= DINAC_SHOW_P1;
    for (int i = 0; i < 12; i++) begin
      if (i == 5) @(posedge clk_i) clk_en <= 1'b1;
      press(1'b1);
      chk(vidx, 16'((i < 5) ? i % 4 : (i - 4) % 7));
    end
    tick(210);
    chk(kind, DINAC_D_VALUE);
    summarize();
  end
endmodule // digital_input_alarm_control_bench
